/* File: hdl/apsw_regs.sv */
// apsw_regs: control register bank with pin, switch, error-flag and special pin logic.
// assumes frames arrive on core_clk from a framer; pins and error sources are asynchronous.
//
// Summary of operation
// - pin data read gives sampled level for inputs, written value for outputs
// - switch register one bits close switches; reset closes only the two A switches
// - switch register two holds F and G switches in bits 3..0, reset open
// - direction bit 0 input, 1 output; all pins input after reset
// - chip-select extension bits enable extended select per pin, single byte write
// - mux drive disable bit stops gain mux address reaching pins; resets 0
// - buffer polarity bit 0 gives active high, 1 gives active low
// - errors suppressed while buffer active unless detect-during-buffer bit is set
// - combined flag ORs sources; mask bit removes source except checksum fault
// - pin three outputs combined flag when output and function bit set
// - no-latch bit makes error bits follow live condition, suppression still applied
// - four-bit field picks suppression delay 0..8,12,16,24,32,48,64,127; reset 4
// - suppression starts at buffer end, or at the event when not blocked
// - checksum enable set only with good checksum; then every transfer needs one
// - oscillator drives pin six when its bit set and pin is output
// - external clock taken from pin six when bit set and pin is input
// - pin five shows buffer active with selected polarity when output
// - pin four rising edge starts buffer after 3-4 ticks, holds, then extends
// - mux function bits drive pins from gain mux address unless disabled
// - read is 0x80 plus address then dummy; write is 0x40 plus address
// - latched error bit stays set until a one is written to it
// - undefined bits ignored on write, read as zero
`timescale 1ns/10ps
`default_nettype none

module apsw_regs #(
  parameter int TICK_DIV = apsw_pkg::TICK_DIV,
  parameter int NUM_PINS = 7,
  parameter int NUM_ERR = 5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sw_reset,
  // register frames
  input wire apsw_pkg::apsw_req_t req,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // neighbouring logic
  input wire logic [2:0] gain_mux_addr,
  input wire logic buf_req,
  input wire logic [NUM_ERR-1:0] err_src,
  // general-purpose pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe,
  // analog and status controls
  output logic [6:0] switch_one,
  output logic [3:0] switch_two,
  output logic [6:0] extended_select_enable,
  output logic ext_clock_selected,
  output logic clock_tick,
  output logic buffer_active,
  output logic combined_error_flag
);

  logic srst;
  assign srst = rst | sw_reset;

  // synchronisers
  logic [NUM_PINS-1:0] pin_meta, pin_sync;
  logic [NUM_ERR-1:0] err_meta, err_sync;
  always_ff @(posedge core_clk) begin
    pin_meta <= gpio_in;
    pin_sync <= pin_meta;
    err_meta <= err_src;
    err_sync <= err_meta;
  end

  // frame decode
  logic [3:0] cmd_addr;
  logic chk_en_reg, chk_block, wr_go, rd_go;
  assign cmd_addr = req.cmd[3:0];
  assign chk_block = chk_en_reg && !req.chk_ok;
  assign wr_go = req.valid && req.cmd[7:4] == apsw_pkg::CMD_WRITE && !chk_block;
  assign rd_go = req.valid && req.cmd[7:4] == apsw_pkg::CMD_READ && !chk_block;

  function automatic logic wr_at(input logic [3:0] off);
    return wr_go && cmd_addr == off;
  endfunction : wr_at

  // error sources {saturation, clamp, output, gain, overvolt} onto byte positions
  function automatic logic [7:0] scatter(input logic [4:0] s);
    logic [7:0] b;
    b = 8'h00;
    b[apsw_pkg::BIT_SATURATION] = s[4];
    b[apsw_pkg::BIT_CLAMP] = s[3];
    b[apsw_pkg::BIT_OUTPUT] = s[2];
    b[apsw_pkg::BIT_GAIN] = s[1];
    b[apsw_pkg::BIT_OVERVOLT] = s[0];
    return b;
  endfunction : scatter

  function automatic logic [4:0] gather(input logic [7:0] b);
    return {b[apsw_pkg::BIT_SATURATION], b[apsw_pkg::BIT_CLAMP], b[apsw_pkg::BIT_OUTPUT],
            b[apsw_pkg::BIT_GAIN], b[apsw_pkg::BIT_OVERVOLT]};
  endfunction : gather

  function automatic logic [6:0] suppress_cycles(input logic [3:0] code);
    unique case (code)
      4'h9: return 7'd12;
      4'ha: return 7'd16;
      4'hb: return 7'd24;
      4'hc: return 7'd32;
      4'hd: return 7'd48;
      4'he: return 7'd64;
      4'hf: return 7'd127;
      default: return {3'b000, code};
    endcase
  endfunction : suppress_cycles

  // configuration registers
  logic [6:0] pin_data_reg, sw_one_reg, dir_reg, ecs_reg;
  logic [3:0] sw_two_reg, flg_reg;
  logic [7:0] mask_reg, special_reg;
  logic ltd_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_data_reg <= apsw_pkg::RST_PIN_DATA[6:0];
      sw_one_reg <= apsw_pkg::RST_SWITCH_ONE[6:0];
      sw_two_reg <= apsw_pkg::RST_SWITCH_TWO[3:0];
      dir_reg <= apsw_pkg::RST_PIN_DIR[6:0];
      ecs_reg <= apsw_pkg::RST_CS_EXT[6:0];
      mask_reg <= apsw_pkg::RST_ERR_MASK;
      special_reg <= apsw_pkg::RST_SPECIAL;
    end else begin
      // bits above each field are dropped on write
      if (wr_at(apsw_pkg::REG_PIN_DATA)) pin_data_reg <= req.data[6:0];
      if (wr_at(apsw_pkg::REG_SWITCH_ONE)) sw_one_reg <= req.data[6:0];
      if (wr_at(apsw_pkg::REG_SWITCH_TWO)) sw_two_reg <= req.data[3:0];
      if (wr_at(apsw_pkg::REG_PIN_DIR)) dir_reg <= req.data[6:0];
      if (wr_at(apsw_pkg::REG_CS_EXT)) ecs_reg <= req.data[6:0];
      if (wr_at(apsw_pkg::REG_ERR_MASK)) mask_reg <= req.data;
      if (wr_at(apsw_pkg::REG_SPECIAL)) special_reg <= req.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ltd_reg <= apsw_pkg::RST_ERR_TIMING[apsw_pkg::BIT_NO_LATCH];
      flg_reg <= apsw_pkg::RST_ERR_TIMING[apsw_pkg::FLD_SUPPRESS_LSB +: 4];
      chk_en_reg <= apsw_pkg::RST_ERR_TIMING[apsw_pkg::BIT_CHK_ENABLE];
    end else if (wr_at(apsw_pkg::REG_ERR_TIMING)) begin
      ltd_reg <= req.data[apsw_pkg::BIT_NO_LATCH];
      flg_reg <= req.data[apsw_pkg::FLD_SUPPRESS_LSB +: 4];
      // enabling needs a good checksum on this very write
      chk_en_reg <= req.data[apsw_pkg::BIT_CHK_ENABLE] && req.chk_ok;
    end
  end

  assign switch_one = sw_one_reg;
  assign switch_two = sw_two_reg;
  assign extended_select_enable = ecs_reg;
  assign gpio_oe = dir_reg;

  // tick: internal divider or external clock on pin six
  localparam int DIV_W = $clog2(TICK_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(TICK_DIV / 2);
  logic [DIV_W-1:0] div_cnt;
  logic osc_level_reg, ext_prev, ext_sel, tick_reg;
  assign ext_sel = special_reg[apsw_pkg::BIT_EXT_CLK_IN] && !dir_reg[apsw_pkg::PIN_OSC];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_cnt <= '0;
      osc_level_reg <= 1'b0;
      ext_prev <= 1'b0;
      tick_reg <= 1'b0;
      ext_clock_selected <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
      osc_level_reg <= div_cnt < DIV_HALF;
      ext_prev <= pin_sync[apsw_pkg::PIN_OSC];
      ext_clock_selected <= ext_sel;
      tick_reg <= ext_sel ? (pin_sync[apsw_pkg::PIN_OSC] && !ext_prev)
                          : (div_cnt == DIV_LAST);
    end
  end
  assign clock_tick = tick_reg;

  // external buffer trigger on pin four
  apsw_pkg::apsw_trig_state_t trig_state;
  logic [7:0] trig_cnt;
  logic trig_prev, trig_en, trig_rise, trig_active;
  logic [6:0] supp;
  assign supp = suppress_cycles(flg_reg);
  assign trig_en = special_reg[apsw_pkg::BIT_TRIG_IN] && !dir_reg[apsw_pkg::PIN_TRIG];
  assign trig_rise = pin_sync[apsw_pkg::PIN_TRIG] && !trig_prev;
  assign trig_active = trig_state == apsw_pkg::TRG_ACTIVE || trig_state == apsw_pkg::TRG_HOLD;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_state <= apsw_pkg::TRG_IDLE;
      trig_cnt <= 8'h00;
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= pin_sync[apsw_pkg::PIN_TRIG];
      unique case (trig_state)
        apsw_pkg::TRG_IDLE: begin
          trig_cnt <= 8'h00;
          if (trig_en && trig_rise) trig_state <= apsw_pkg::TRG_START;
        end
        apsw_pkg::TRG_START: begin
          if (!trig_en) begin
            trig_state <= apsw_pkg::TRG_IDLE;
          end else if (tick_reg) begin
            trig_cnt <= trig_cnt + 8'h01;
            if (trig_cnt == 8'(apsw_pkg::TRIG_DELAY_TICKS - 1)) begin
              trig_state <= apsw_pkg::TRG_ACTIVE;
            end
          end
        end
        apsw_pkg::TRG_ACTIVE: begin
          trig_cnt <= 8'h00;
          if (!pin_sync[apsw_pkg::PIN_TRIG] || !trig_en) trig_state <= apsw_pkg::TRG_HOLD;
        end
        apsw_pkg::TRG_HOLD: begin
          // extension: trigger delay plus suppression time
          if (pin_sync[apsw_pkg::PIN_TRIG] && trig_en) begin
            trig_state <= apsw_pkg::TRG_ACTIVE;
          end else if (tick_reg) begin
            trig_cnt <= trig_cnt + 8'h01;
            if (trig_cnt + 8'h01 >= 8'(apsw_pkg::TRIG_DELAY_TICKS) + {1'b0, supp}) begin
              trig_state <= apsw_pkg::TRG_IDLE;
            end
          end
        end
      endcase
    end
  end

  logic buf_active_reg;
  always_ff @(posedge core_clk) begin
    if (srst) buf_active_reg <= 1'b0;
    else buf_active_reg <= buf_req || trig_active;
  end
  assign buffer_active = buf_active_reg;

  // error qualification, latching and combination
  logic blocked;
  logic [NUM_ERR-1:0] qual, err_reg, err_view, err_clr;
  assign blocked = buf_active_reg && !mask_reg[apsw_pkg::BIT_DETECT_IN_BUF];
  assign err_clr = wr_at(apsw_pkg::REG_ERROR) ? gather(req.data) : '0;

  for (genvar g = 0; g < NUM_ERR; g++) begin : g_src
    logic [6:0] cnt_reg;
    always_ff @(posedge core_clk) begin
      if (srst || !err_sync[g] || blocked) cnt_reg <= 7'h00;
      else if (tick_reg && cnt_reg != 7'h7f) cnt_reg <= cnt_reg + 7'h01;
    end
    assign qual[g] = err_sync[g] && !blocked && cnt_reg >= supp;
    always_ff @(posedge core_clk) begin
      if (srst) err_reg[g] <= 1'b0;
      else if (qual[g]) err_reg[g] <= 1'b1;
      else if (err_clr[g]) err_reg[g] <= 1'b0;
    end
  end

  assign err_view = ltd_reg ? qual : err_reg;

  logic chk_fault_reg, ef_calc;
  always_ff @(posedge core_clk) begin
    if (srst) chk_fault_reg <= 1'b0;
    else if (req.valid && chk_block) chk_fault_reg <= 1'b1;
    else if (wr_at(apsw_pkg::REG_ERROR) && req.data[apsw_pkg::BIT_CHK_FAULT]) begin
      chk_fault_reg <= 1'b0;
    end
  end

  assign ef_calc = |(err_view & ~gather(mask_reg)) || chk_fault_reg;
  always_ff @(posedge core_clk) begin
    if (srst) combined_error_flag <= 1'b0;
    else combined_error_flag <= ef_calc;
  end

  // pin outputs, special functions over general data
  logic [NUM_PINS-1:0] out_next;
  logic buf_pin_level;
  assign buf_pin_level = buf_active_reg ^ mask_reg[apsw_pkg::BIT_BUF_POL];
  always_comb begin
    out_next = pin_data_reg;
    for (int i = 0; i < 3; i++) begin
      if (special_reg[i] && !mask_reg[apsw_pkg::BIT_MUX_DISABLE]) begin
        out_next[i] = gain_mux_addr[i];
      end
    end
    if (special_reg[apsw_pkg::BIT_EF_OUT]) begin
      out_next[apsw_pkg::PIN_EF] = combined_error_flag;
    end
    if (special_reg[apsw_pkg::BIT_BUF_PIN_OUT]) begin
      out_next[apsw_pkg::PIN_BUF] = buf_pin_level;
    end
    if (special_reg[apsw_pkg::BIT_OSC_OUT]) begin
      out_next[apsw_pkg::PIN_OSC] = osc_level_reg;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) gpio_out <= '0;
    else gpio_out <= out_next;
  end

  // read path
  logic [6:0] pin_view;
  logic [7:0] rd_data;
  assign pin_view = (pin_data_reg & dir_reg) | (pin_sync & ~dir_reg);
  always_comb begin
    rd_data = 8'h00;
    unique case (cmd_addr)
      apsw_pkg::REG_ERROR: begin
        rd_data = scatter(err_view);
        rd_data[apsw_pkg::BIT_CHK_FAULT] = chk_fault_reg;
        rd_data[apsw_pkg::BIT_BUF_ACTIVE] = buf_active_reg;
        rd_data[apsw_pkg::BIT_EF] = combined_error_flag;
      end
      apsw_pkg::REG_PIN_DATA: rd_data = {1'b0, pin_view};
      apsw_pkg::REG_SWITCH_ONE: rd_data = {1'b0, sw_one_reg};
      apsw_pkg::REG_SWITCH_TWO: rd_data = {4'h0, sw_two_reg};
      apsw_pkg::REG_PIN_DIR: rd_data = {1'b0, dir_reg};
      apsw_pkg::REG_CS_EXT: rd_data = {1'b0, ecs_reg};
      apsw_pkg::REG_ERR_MASK: rd_data = mask_reg;
      apsw_pkg::REG_ERR_TIMING: rd_data = {ltd_reg, 1'b0, flg_reg, 1'b0, chk_en_reg};
      apsw_pkg::REG_SPECIAL: rd_data = special_reg;
      default: rd_data = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= rd_go;
      rsp_data <= rd_go ? rd_data : 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_pin_readback: assert property (rd_go && cmd_addr == apsw_pkg::REG_PIN_DATA
    |=> rsp_valid && rsp_data[6:0] == $past(pin_view)) else $error("pin readback wrong");
  chk_switch_reset: assert property (disable iff (1'b0) rst
    |=> switch_one == 7'h60 && switch_two == 4'h0) else $error("switch reset wrong");
  chk_dir_write: assert property (wr_at(apsw_pkg::REG_PIN_DIR)
    |=> gpio_oe == $past(req.data[6:0])) else $error("direction not taken");
  chk_mux_blocked: assert property (mask_reg[7] && special_reg[0]
    |=> gpio_out[0] == $past(pin_data_reg[0])) else $error("mux drive not disabled");
  chk_mux_drive: assert property (!mask_reg[7] && special_reg[1]
    |=> gpio_out[1] == $past(gain_mux_addr[1])) else $error("mux address not driven");
  chk_buf_pin: assert property (special_reg[5]
    |=> gpio_out[5] == $past(buf_pin_level)) else $error("buffer pin wrong");
  chk_suppress_buf: assert property (blocked
    |=> (err_reg & ~$past(err_reg)) == '0) else $error("error during buffer");
  chk_ef_pin: assert property (special_reg[3] ##1 special_reg[3]
    |=> gpio_out[3] == $past(ef_calc, 2)) else $error("error flag pin wrong");
  chk_err_hold: assert property (err_reg[0] && !err_clr[0] |=> err_reg[0])
    else $error("latched error lost");
  chk_chk_enable: assert property (wr_at(apsw_pkg::REG_ERR_TIMING) && !req.chk_ok
    |=> !chk_en_reg) else $error("checksum enabled without good checksum");
  chk_trig_start: assert property ($rose(trig_active)
    |-> $past(trig_state) == apsw_pkg::TRG_START) else $error("trigger skipped delay");
  chk_no_read: assert property (!rd_go |=> !rsp_valid)
    else $error("spurious response");

  cov_trigger: cover property (trig_en && trig_rise ##[1:400] trig_active);
  cov_chk_fault: cover property (chk_en_reg ##1 chk_fault_reg);
  cov_err_latch: cover property (qual[2] ##1 err_reg[2]);
  cov_ext_clock: cover property (ext_sel && tick_reg);

endmodule : apsw_regs

`default_nettype wire

/* File: hdl/apsw_pkg.sv */
// apsw_pkg: constants, register map and carrier types for the pin, switch and error bank.
// assumes one core clock; the serial framer outside hands over decoded byte frames.
package apsw_pkg;

  // clocking
  localparam int CORE_CLK_HZ = 40_000_000;
  localparam int INT_OSC_HZ = 1_000_000;
  localparam int TICK_DIV = CORE_CLK_HZ / INT_OSC_HZ;
  localparam int TRIG_DELAY_TICKS = 3;

  // command byte prefixes (upper nibble), address in lower nibble
  localparam logic [3:0] CMD_READ = 4'h8;
  localparam logic [3:0] CMD_WRITE = 4'h4;

  // register offsets
  localparam logic [3:0] REG_ERROR = 4'h4;
  localparam logic [3:0] REG_PIN_DATA = 4'h5;
  localparam logic [3:0] REG_SWITCH_ONE = 4'h6;
  localparam logic [3:0] REG_SWITCH_TWO = 4'h7;
  localparam logic [3:0] REG_PIN_DIR = 4'h8;
  localparam logic [3:0] REG_CS_EXT = 4'h9;
  localparam logic [3:0] REG_ERR_MASK = 4'ha;
  localparam logic [3:0] REG_ERR_TIMING = 4'hb;
  localparam logic [3:0] REG_SPECIAL = 4'hc;

  // reset values
  localparam logic [7:0] RST_PIN_DATA = 8'h00;
  localparam logic [7:0] RST_SWITCH_ONE = 8'h60;
  localparam logic [7:0] RST_SWITCH_TWO = 8'h00;
  localparam logic [7:0] RST_PIN_DIR = 8'h00;
  localparam logic [7:0] RST_CS_EXT = 8'h00;
  localparam logic [7:0] RST_ERR_MASK = 8'h00;
  localparam logic [7:0] RST_ERR_TIMING = 8'h10;
  localparam logic [7:0] RST_SPECIAL = 8'h00;

  // error register / mask register bit positions
  localparam int BIT_CHK_FAULT = 7;
  localparam int BIT_SATURATION = 6;
  localparam int BIT_BUF_ACTIVE = 5;
  localparam int BIT_CLAMP = 4;
  localparam int BIT_EF = 3;
  localparam int BIT_OUTPUT = 2;
  localparam int BIT_GAIN = 1;
  localparam int BIT_OVERVOLT = 0;
  // mask register control bits
  localparam int BIT_MUX_DISABLE = 7;
  localparam int BIT_BUF_POL = 5;
  localparam int BIT_DETECT_IN_BUF = 3;
  // timing register fields
  localparam int BIT_NO_LATCH = 7;
  localparam int FLD_SUPPRESS_LSB = 2;
  localparam int BIT_CHK_ENABLE = 0;
  // special function bits
  localparam int BIT_OSC_OUT = 7;
  localparam int BIT_EXT_CLK_IN = 6;
  localparam int BIT_BUF_PIN_OUT = 5;
  localparam int BIT_TRIG_IN = 4;
  localparam int BIT_EF_OUT = 3;
  // pins carrying special functions
  localparam int PIN_EF = 3;
  localparam int PIN_TRIG = 4;
  localparam int PIN_BUF = 5;
  localparam int PIN_OSC = 6;

  // one decoded frame from the serial framer
  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [7:0] data;
    logic chk_ok;
  } apsw_req_t;

  typedef enum logic [1:0] {TRG_IDLE, TRG_START, TRG_ACTIVE, TRG_HOLD} apsw_trig_state_t;

endpackage : apsw_pkg

/* File: verification/apsw_host.sv */
// apsw_host: host side of the register port, sends decoded frames and takes answers.
// assumes frames are launched at the falling edge of core_clk, one frame per cycle pair.
`timescale 1ns/10ps
`default_nettype none

module apsw_host (
  // clock
  input wire logic core_clk,
  // frames to the bank
  output var apsw_pkg::apsw_req_t req,
  // answers
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data
);
  initial req = '0;

  task automatic wr(input logic [3:0] addr, input logic [7:0] data, input logic ok);
    @(negedge core_clk);
    req <= {1'b1, apsw_pkg::CMD_WRITE, addr, data, ok};
    @(negedge core_clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] addr, input logic ok, output logic [7:0] data,
                    output logic got);
    @(negedge core_clk);
    req <= {1'b1, apsw_pkg::CMD_READ, addr, 8'h00, ok};
    @(negedge core_clk);
    req <= '0;
    got = rsp_valid;
    data = rsp_data;
  endtask : rd
endmodule : apsw_host

`default_nettype wire

/* File: verification/test_apsw_regs.sv */
// test_apsw_regs: register, pin, buffer and error flag checks through the host model.
// assumes a small tick divider; pins and error sources are driven here at the falling edge.
`timescale 1ns/10ps
`default_nettype none

module test_apsw_regs;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sw_reset = 1'b0;
  apsw_pkg::apsw_req_t req;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic [2:0] gain_mux_addr = 3'h5;
  logic buf_req = 1'b0;
  logic [4:0] err_src = 5'h00;
  logic [6:0] gpio_in = 7'h00;
  logic [6:0] gpio_out, gpio_oe, switch_one, extended_select_enable;
  logic [3:0] switch_two;
  logic ext_clock_selected, clock_tick, buffer_active, combined_error_flag;
  logic [7:0] rst_val [5:12] = '{8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
  logic [7:0] v;
  logic got;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #12.5 core_clk = ~core_clk;

  apsw_host host (.core_clk(core_clk), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

  apsw_regs #(.TICK_DIV(4)) dut (
    .core_clk(core_clk), .rst(rst), .sw_reset(sw_reset), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .gain_mux_addr(gain_mux_addr),
    .buf_req(buf_req), .err_src(err_src), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .switch_one(switch_one), .switch_two(switch_two),
    .extended_select_enable(extended_select_enable), .ext_clock_selected(ext_clock_selected),
    .clock_tick(clock_tick), .buffer_active(buffer_active),
    .combined_error_flag(combined_error_flag)
  );

  task automatic end_of_test;
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rc(input logic [3:0] addr, input logic [7:0] exp);
    host.rd(addr, 1'b1, v, got);
    check("answer", {7'h00, got}, 8'h01);
    check($sformatf("reg %h", addr), v, exp);
  endtask : rc

  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask : w

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    // reset values and unmapped place
    for (int a = 5; a <= 12; a++) rc(a[3:0], rst_val[a]);
    check("sw one", {1'b0, switch_one}, 8'h60);
    rc(4'hd, 8'h00);
    // undefined top bits ignored
    host.wr(4'h6, 8'hff, 1'b1);
    host.wr(4'h7, 8'hff, 1'b1);
    host.wr(4'h9, 8'hff, 1'b1);
    rc(4'h6, 8'h7f);
    rc(4'h7, 8'h0f);
    rc(4'h9, 8'h7f);
    check("sw two", {4'h0, switch_two}, 8'h0f);
    check("ecs", {1'b0, extended_select_enable}, 8'h7f);
    host.wr(4'h6, 8'h18, 1'b1);
    w(2);
    check("sw one", {1'b0, switch_one}, 8'h18);
    // mixed direction pin view
    host.wr(4'h5, 8'h2a, 1'b1);
    host.wr(4'h8, 8'h0f, 1'b1);
    gpio_in = 7'h45;
    w(4);
    rc(4'h5, 8'h4a);
    check("oe", {1'b0, gpio_oe}, 8'h0f);
    check("out", {4'h0, gpio_out[3:0]}, 8'h0a);
    // mux address onto pins, then disabled
    host.wr(4'hc, 8'h07, 1'b1);
    w(2);
    check("mux", {5'h00, gpio_out[2:0]}, 8'h05);
    host.wr(4'ha, 8'h80, 1'b1);
    w(2);
    check("mux off", {5'h00, gpio_out[2:0]}, 8'h02);
    host.wr(4'ha, 8'h00, 1'b1);
    // latched error, flag pin, mask and clear
    host.wr(4'h8, 8'h28, 1'b1);
    host.wr(4'hc, 8'h28, 1'b1);
    host.wr(4'hb, 8'h00, 1'b1);
    err_src = 5'h01;
    w(40);
    check("flag pin", {7'h00, gpio_out[3]}, 8'h01);
    err_src = 5'h00;
    w(40);
    rc(4'h4, 8'h09);
    host.wr(4'ha, 8'h01, 1'b1);
    w(4);
    check("flag", {7'h00, combined_error_flag}, 8'h00);
    host.wr(4'h4, 8'h01, 1'b1);
    rc(4'h4, 8'h00);
    host.wr(4'ha, 8'h00, 1'b1);
    // suppression code 1001 gives 12 ticks
    host.wr(4'hb, 8'h24, 1'b1);
    err_src = 5'h02;
    w(30);
    check("flag", {7'h00, combined_error_flag}, 8'h00);
    w(50);
    check("flag", {7'h00, combined_error_flag}, 8'h01);
    err_src = 5'h00;
    host.wr(4'hb, 8'h00, 1'b1);
    host.wr(4'h4, 8'h02, 1'b1);
    // errors held off while the buffer runs
    buf_req = 1'b1;
    w(4);
    check("buf pin", {7'h00, gpio_out[5]}, 8'h01);
    err_src = 5'h04;
    w(40);
    check("flag", {7'h00, combined_error_flag}, 8'h00);
    buf_req = 1'b0;
    w(20);
    check("flag", {7'h00, combined_error_flag}, 8'h01);
    err_src = 5'h00;
    w(4);
    host.wr(4'h4, 8'h04, 1'b1);
    host.wr(4'ha, 8'h20, 1'b1);
    w(3);
    check("buf pol", {7'h00, gpio_out[5]}, 8'h01);
    // checksum enable needs a good checksum, then bad frames drop
    host.wr(4'hb, 8'h01, 1'b0);
    rc(4'hb, 8'h00);
    host.wr(4'hb, 8'h01, 1'b1);
    rc(4'hb, 8'h01);
    host.rd(4'h5, 1'b0, v, got);
    check("dropped", {7'h00, got}, 8'h00);
    w(2);
    rc(4'h4, 8'h88);
    // software reset restores the bank
    @(negedge core_clk) sw_reset = 1'b1;
    @(negedge core_clk) sw_reset = 1'b0;
    rc(4'hb, 8'h10);
    rc(4'h6, 8'h60);
    // pin six as external clock: one tick per rising edge
    host.wr(4'hc, 8'h40, 1'b1);
    w(2);
    check("ext sel", {7'h00, ext_clock_selected}, 8'h01);
    v = 8'h00;
    for (int i = 0; i < 24; i++) begin
      gpio_in[6] = i[2];
      w(1);
      v = v + {7'h00, clock_tick};
    end
    check("ticks", v, 8'h03);
    // internal oscillator onto pin six, half high
    host.wr(4'h8, 8'h40, 1'b1);
    host.wr(4'hc, 8'h80, 1'b1);
    w(2);
    check("ext sel", {7'h00, ext_clock_selected}, 8'h00);
    v = 8'h00;
    repeat (8) begin
      w(1);
      v = v + {7'h00, gpio_out[6]};
    end
    check("osc high", v, 8'h04);
    // live error bits, detection kept on during the buffer
    host.wr(4'hb, 8'h80, 1'b1);
    host.wr(4'ha, 8'h08, 1'b1);
    buf_req = 1'b1;
    err_src = 5'h01;
    w(8);
    rc(4'h4, 8'h29);
    err_src = 5'h00;
    w(4);
    rc(4'h4, 8'h20);
    buf_req = 1'b0;
    // external trigger starts the buffer after three to four ticks
    gpio_in = 7'h00;
    host.wr(4'hc, 8'h10, 1'b1);
    w(4);
    gpio_in = 7'h10;
    w(6);
    check("trig", {7'h00, buffer_active}, 8'h00);
    w(24);
    check("trig", {7'h00, buffer_active}, 8'h01);
    end_of_test();
  end
endmodule : test_apsw_regs

`default_nettype wire
